// file: src/mdf_defines.vh
// Constants of the multidrop message framer
`ifndef MDF_DEFINES_VH
`define MDF_DEFINES_VH

// =====================================================
// Framing characters
`define MDF_GUARD 8'hff
`define MDF_GUARD7 8'h7f
`define MDF_STX 8'h02
`define MDF_CR 8'h0d
`define MDF_ZERO 8'h30
`define MDF_UNIT_BCAST 8'h00

// =====================================================
// Message type low digits
`define MDF_T_POLL 8'h31
`define MDF_T_DATA 8'h32
`define MDF_T_ACK 8'h33
`define MDF_T_WAKE 8'h34
`define MDF_T_NODATA 8'h35

// =====================================================
// Character formats
`define MDF_BITS7 4'h7
`define MDF_BITS8 4'h8
`define MDF_STOPS7 2'h2
`define MDF_STOPS8 2'h1

// =====================================================
// Transmit steps
`define MDF_STEP_GUARD 4'h0
`define MDF_STEP_STX 4'h1
`define MDF_STEP_IDHI 4'h2
`define MDF_STEP_IDLO 4'h3
`define MDF_STEP_TYHI 4'h4
`define MDF_STEP_TYLO 4'h5
`define MDF_STEP_SEQ 4'h6
`define MDF_STEP_DATA 4'h7
`define MDF_STEP_LRCH 4'h8
`define MDF_STEP_LRCL 4'h9
`define MDF_STEP_CR 4'ha

// =====================================================
// Sequence digit, timing and FIFO size
`define MDF_SEQ_FIRST 4'h1
`define MDF_SEQ_LAST 4'h9
`define MDF_CHAR_BITS 10
`define MDF_BIT_CYCLES 868
`define MDF_CNT_W 20
`define MDF_FIFO_DEPTH 32
`define MDF_FIFO_WIDTH 9

`endif

// file: src/mdf_fifo.v
// Synchronous FIFO with valid and ready on both sides
`include "mdf_defines.vh"

module mdf_fifo #(
   parameter WIDTH = `MDF_FIFO_WIDTH,
   parameter DEPTH = `MDF_FIFO_DEPTH,
   parameter AW = 5
) (
   input wire clk,
   input wire rst,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_q;
   reg [AW:0] rd_q;
   wire push;
   wire pop;

   // =====================================================
   // Pointers carry one extra bit to tell full from empty
   assign out_valid = wr_q != rd_q;
   assign in_ready = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_q[AW-1:0]];

   always @(posedge clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_q <= {(AW+1){1'b0}};
         rd_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

endmodule // mdf_fifo

// file: src/mdf_framer.v
// Polled-device framer and parser for a multidrop ASCII message link
`include "mdf_defines.vh"

module mdf_framer #(
   parameter CHAR_CYCLES = `MDF_CHAR_BITS * `MDF_BIT_CYCLES,
   parameter DEPTH = `MDF_FIFO_DEPTH
) (
   input wire clk,
   input wire rst,
   input wire [7:0] unit_number,
   input wire link_8bit,
   input wire guard_omit,
   input wire nodata_en,
   input wire rx_valid,
   input wire [7:0] rx_char,
   input wire rx_perr,
   output wire tx_valid,
   input wire tx_ready,
   output wire [7:0] tx_char,
   input wire tx_empty,
   output wire drv_en,
   output wire [3:0] fmt_data_bits,
   output wire fmt_parity_odd,
   output wire [1:0] fmt_stop_bits,
   input wire msg_valid,
   output wire msg_ready,
   input wire [7:0] msg_data,
   input wire msg_last,
   output wire rx_data_valid,
   output wire [7:0] rx_data,
   output wire rx_msg_ok,
   output wire rx_msg_drop,
   output wire rx_bcast,
   output wire rx_wake,
   output wire rx_ack
);

   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_TURN = 4'b0010;
   localparam [3:0] ST_SEND = 4'b0100;
   localparam [3:0] ST_DRAIN = 4'b1000;
   localparam integer GUARD_WAIT_I = CHAR_CYCLES - 1;
   localparam [`MDF_CNT_W-1:0] GUARD_WAIT = GUARD_WAIT_I[`MDF_CNT_W-1:0];

   function [7:0] hex_asc;
      input [3:0] n;
      begin
         hex_asc = (n < 4'ha) ? {4'h3, n} : {4'h4, n - 4'h9};
      end
   endfunction

   function [7:0] dig_asc;
      input [3:0] n;
      begin
         dig_asc = {4'h3, n};
      end
   endfunction

   // =====================================================
   // Configuration
   reg link_8bit_q;
   reg guard_omit_q;
   reg nodata_en_q;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         link_8bit_q <= 1'b0;
         guard_omit_q <= 1'b0;
         nodata_en_q <= 1'b0;
      end else begin
         link_8bit_q <= link_8bit;
         guard_omit_q <= guard_omit;
         nodata_en_q <= nodata_en;
      end
   end

   assign fmt_data_bits = link_8bit_q ? `MDF_BITS8 : `MDF_BITS7;
   assign fmt_parity_odd = link_8bit_q;
   assign fmt_stop_bits = link_8bit_q ? `MDF_STOPS8 : `MDF_STOPS7;

   // =====================================================
   // Outgoing data FIFO
   wire q_valid;
   wire q_ready;
   wire [8:0] q_word;
   reg [5:0] msgs_q;
   wire msg_ready_w;
   wire push_last = msg_valid & msg_ready_w & msg_last;
   wire pop_last = q_valid & q_ready & q_word[8];

   assign msg_ready = msg_ready_w;

   mdf_fifo #(
      .WIDTH(`MDF_FIFO_WIDTH),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(msg_valid),
      .in_ready(msg_ready_w),
      .in_data({msg_last, msg_data}),
      .out_valid(q_valid),
      .out_ready(q_ready),
      .out_data(q_word)
   );

   // Whole messages queued, so a reply never waits mid-data
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         msgs_q <= 6'h00;
      end else if (push_last & ~pop_last) begin
         msgs_q <= msgs_q + 6'h01;
      end else if (pop_last & ~push_last) begin
         msgs_q <= msgs_q - 6'h01;
      end
   end

   // =====================================================
   // Receive parser
   reg [3:0] state_q;
   reg in_msg_q, bad_q, emitted_q;
   reg [7:0] pos_q, p0_q, p1_q, lrc_q;
   reg [7:0] id_hi_q, id_lo_q, ty_hi_q, ty_lo_q, seq_in_q, last_seq_q;
   reg rx_data_valid_q, rx_msg_ok_q, rx_msg_drop_q, rx_bcast_q;
   reg rx_wake_q, rx_ack_q;
   reg [7:0] rx_data_q;

   wire [7:0] rc = link_8bit_q ? rx_char : {1'b0, rx_char[6:0]};
   wire rx_take = rx_valid & (state_q == ST_IDLE);
   wire is_guard = rc == (link_8bit_q ? `MDF_GUARD : `MDF_GUARD7);
   wire [7:0] idx = pos_q - 8'h02;
   wire own_id = (id_hi_q == dig_asc(unit_number[7:4])) &&
      (id_lo_q == dig_asc(unit_number[3:0]));
   wire bcast_id = (id_hi_q == `MDF_ZERO) && (id_lo_q == `MDF_ZERO);
   wire addressed = own_id | bcast_id;
   wire ty_data = (ty_hi_q == `MDF_ZERO) && (ty_lo_q == `MDF_T_DATA);
   wire ty_ok = (ty_hi_q == `MDF_ZERO) && (ty_lo_q >= `MDF_T_POLL) &&
      (ty_lo_q <= `MDF_T_NODATA);
   wire lrc_ok = (p1_q == hex_asc(lrc_q[7:4])) &&
      (p0_q == hex_asc(lrc_q[3:0]));
   wire len_ok = ty_data ? (pos_q >= 8'h07) : (pos_q == 8'h06);
   wire cr_in = rx_take & in_msg_q & (rc == `MDF_CR);
   wire frame_ok = cr_in & ~bad_q & ty_ok & lrc_ok & len_ok;
   wire dup = (seq_in_q == last_seq_q) && (seq_in_q != `MDF_ZERO);
   wire deliver = frame_ok & ty_data & addressed & ~dup;
   wire want_ack = frame_ok & own_id &
      (ty_data | (ty_lo_q == `MDF_T_WAKE));
   wire want_poll = frame_ok & own_id & (ty_lo_q == `MDF_T_POLL);
   wire reply_go = want_ack | (want_poll & ((msgs_q != 6'h00) | nodata_en_q));
   wire [7:0] reply_kind = want_ack ? `MDF_T_ACK :
      (msgs_q != 6'h00) ? `MDF_T_DATA : `MDF_T_NODATA;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         in_msg_q <= 1'b0;
         bad_q <= 1'b0;
         emitted_q <= 1'b0;
         pos_q <= 8'h00;
         p0_q <= 8'h00;
         p1_q <= 8'h00;
         lrc_q <= 8'h00;
         id_hi_q <= 8'h00;
         id_lo_q <= 8'h00;
         ty_hi_q <= 8'h00;
         ty_lo_q <= 8'h00;
         seq_in_q <= 8'h00;
         last_seq_q <= 8'h00;
         rx_data_q <= 8'h00;
         rx_data_valid_q <= 1'b0;
         rx_msg_ok_q <= 1'b0;
         rx_msg_drop_q <= 1'b0;
         rx_bcast_q <= 1'b0;
         rx_wake_q <= 1'b0;
         rx_ack_q <= 1'b0;
      end else begin
         rx_data_valid_q <= 1'b0;
         rx_msg_ok_q <= 1'b0;
         rx_msg_drop_q <= 1'b0;
         rx_wake_q <= 1'b0;
         rx_ack_q <= 1'b0;
         if (rx_take & is_guard) begin
            // Guard never enters the message
         end else if (rx_take & (rc == `MDF_STX)) begin
            in_msg_q <= 1'b1;
            bad_q <= rx_perr;
            pos_q <= 8'h00;
            lrc_q <= 8'h00;
            emitted_q <= 1'b0;
            rx_msg_drop_q <= emitted_q;
         end else if (cr_in) begin
            in_msg_q <= 1'b0;
            emitted_q <= 1'b0;
            rx_msg_ok_q <= deliver;
            rx_msg_drop_q <= emitted_q & ~deliver;
            rx_bcast_q <= bcast_id;
            rx_wake_q <= frame_ok & addressed & (ty_lo_q == `MDF_T_WAKE);
            rx_ack_q <= frame_ok & own_id & (ty_lo_q == `MDF_T_ACK);
            if (deliver) begin
               last_seq_q <= seq_in_q;
            end
         end else if (rx_take & in_msg_q) begin
            bad_q <= bad_q | rx_perr;
            p0_q <= rc;
            p1_q <= p0_q;
            if (pos_q != 8'hff) begin
               pos_q <= pos_q + 8'h01;
            end
            if (pos_q >= 8'h02) begin
               lrc_q <= lrc_q ^ p1_q;
               case (idx)
                  8'h00: id_hi_q <= p1_q;
                  8'h01: id_lo_q <= p1_q;
                  8'h02: ty_hi_q <= p1_q;
                  8'h03: ty_lo_q <= p1_q;
                  8'h04: begin
                     if (ty_data) begin
                        seq_in_q <= p1_q;
                     end else begin
                        bad_q <= 1'b1;
                     end
                  end
                  default: begin
                     if (ty_data & addressed) begin
                        rx_data_q <= p1_q;
                        rx_data_valid_q <= 1'b1;
                        emitted_q <= 1'b1;
                     end
                  end
               endcase
            end
         end
      end
   end

   assign rx_data_valid = rx_data_valid_q;
   assign rx_data = rx_data_q;
   assign rx_msg_ok = rx_msg_ok_q;
   assign rx_msg_drop = rx_msg_drop_q;
   assign rx_bcast = rx_bcast_q;
   assign rx_wake = rx_wake_q;
   assign rx_ack = rx_ack_q;

   // =====================================================
   // Transmit sequencer
   reg [3:0] step_q;
   reg [7:0] kind_q, tx_lrc_q, tx_char_q;
   reg [3:0] seq_q;
   reg tx_valid_q, drv_en_q;
   reg [`MDF_CNT_W-1:0] wait_q;
   reg [7:0] step_char;

   wire load = ~tx_valid_q | tx_ready;
   wire kind_data = kind_q == `MDF_T_DATA;
   wire step_go = (state_q == ST_SEND) & load &
      ((step_q != `MDF_STEP_DATA) | q_valid);
   assign q_ready = (state_q == ST_SEND) & load &
      (step_q == `MDF_STEP_DATA);

   always @* begin
      case (step_q)
         `MDF_STEP_GUARD: step_char = `MDF_GUARD;
         `MDF_STEP_STX: step_char = `MDF_STX;
         `MDF_STEP_IDHI: step_char = dig_asc(unit_number[7:4]);
         `MDF_STEP_IDLO: step_char = dig_asc(unit_number[3:0]);
         `MDF_STEP_TYHI: step_char = `MDF_ZERO;
         `MDF_STEP_TYLO: step_char = kind_q;
         `MDF_STEP_SEQ: step_char = dig_asc(seq_q);
         `MDF_STEP_DATA: step_char = q_word[7:0];
         `MDF_STEP_LRCH: step_char = hex_asc(tx_lrc_q[7:4]);
         `MDF_STEP_LRCL: step_char = hex_asc(tx_lrc_q[3:0]);
         default: step_char = `MDF_CR;
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         step_q <= `MDF_STEP_GUARD;
         kind_q <= `MDF_T_ACK;
         tx_lrc_q <= 8'h00;
         tx_char_q <= 8'h00;
         tx_valid_q <= 1'b0;
         drv_en_q <= 1'b0;
         seq_q <= 4'h0;
         wait_q <= {`MDF_CNT_W{1'b0}};
      end else begin
         if (step_go) begin
            tx_valid_q <= 1'b1;
            tx_char_q <= step_char;
         end else if (tx_ready) begin
            tx_valid_q <= 1'b0;
         end
         case (state_q)
            ST_IDLE: begin
               if (reply_go) begin
                  state_q <= ST_TURN;
                  kind_q <= reply_kind;
                  drv_en_q <= 1'b1;
                  wait_q <= {`MDF_CNT_W{1'b0}};
                  tx_lrc_q <= 8'h00;
               end
            end
            ST_TURN: begin
               if (~guard_omit_q) begin
                  state_q <= ST_SEND;
                  step_q <= `MDF_STEP_GUARD;
               end else if (wait_q == GUARD_WAIT) begin
                  state_q <= ST_SEND;
                  step_q <= `MDF_STEP_STX;
               end else begin
                  wait_q <= wait_q + 1'b1;
               end
            end
            ST_SEND: begin
               if (step_go) begin
                  if ((step_q >= `MDF_STEP_IDHI) &&
                      (step_q <= `MDF_STEP_DATA)) begin
                     tx_lrc_q <= tx_lrc_q ^ step_char;
                  end
                  if (step_q == `MDF_STEP_TYLO && ~kind_data) begin
                     step_q <= `MDF_STEP_LRCH;
                  end else if (step_q == `MDF_STEP_DATA && ~q_word[8]) begin
                     step_q <= `MDF_STEP_DATA;
                  end else if (step_q == `MDF_STEP_CR) begin
                     state_q <= ST_DRAIN;
                     if (kind_data) begin
                        seq_q <= (seq_q == `MDF_SEQ_LAST) ? `MDF_SEQ_FIRST :
                           seq_q + 4'h1;
                     end
                  end else begin
                     step_q <= step_q + 4'h1;
                  end
               end
            end
            ST_DRAIN: begin
               if (~tx_valid_q & tx_empty) begin
                  state_q <= ST_IDLE;
                  drv_en_q <= 1'b0;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               drv_en_q <= 1'b0;
            end
         endcase
      end
   end

   assign tx_valid = tx_valid_q;
   assign tx_char = tx_char_q;
   assign drv_en = drv_en_q;

endmodule // mdf_framer

// file: verification/mdf_framer_assertions.sv
// Port assertions of the multidrop framer
module mdf_chk #(
   parameter CHAR_CYCLES = 8680
) (
   input wire clk,
   input wire rst,
   input wire link_8bit,
   input wire rx_valid,
   input wire [7:0] rx_char,
   input wire tx_valid,
   input wire tx_ready,
   input wire [7:0] tx_char,
   input wire tx_empty,
   input wire drv_en,
   input wire [3:0] fmt_data_bits,
   input wire fmt_parity_odd,
   input wire [1:0] fmt_stop_bits,
   input wire rx_msg_ok,
   input wire rx_msg_drop,
   input wire rx_wake,
   input wire rx_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIM = 2 * CHAR_CYCLES + 4;
   localparam int HALF = CHAR_CYCLES / 2;
   logic cr_q;
   // ==========
   // Carriage return taken last cycle
   always @(posedge clk or posedge rst) begin
      if (rst)
         cr_q <= 1'b0;
      else
         cr_q <= rx_valid && rx_char[6:0] == 7'h0d;
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_take;
      tx_valid && tx_ready;
   endsequence
   sequence s_cr_out;
      s_take ##0 tx_char[6:0] == 7'h0d;
   endsequence
   // ==========
   // Properties
   chk_drv_cause: assert property (
      $rose(drv_en) |-> cr_q) else $error("driver on without CR");
   chk_tx_drv: assert property (
      tx_valid |-> drv_en) else $error("char offered, driver off");
   chk_drv_hold: assert property (
      drv_en && !tx_empty |=> drv_en) else $error("driver off early");
   chk_cr_release: assert property (
      s_cr_out |-> ##[1:40] !drv_en) else $error("driver left on");
   chk_reply_start: assert property (
      $rose(drv_en) |-> ##[1:LIM] tx_valid) else $error("late reply");
   chk_gap_limit: assert property (
      s_take ##0 tx_char[6:0] != 7'h0d |=> ##[0:HALF] tx_valid)
      else $error("gap between chars");
   chk_tx_hold: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
      else $error("char changed before accept");
   chk_end_on_cr: assert property (
      rx_msg_ok || rx_wake || rx_ack |-> cr_q)
      else $error("message result without CR");
   chk_ok_drop: assert property (
      rx_msg_ok |-> !rx_msg_drop) else $error("kept and dropped");
   chk_fmt_mode: assert property (
      !$past(rst) |-> fmt_data_bits == (link_8bit ? 4'h8 : 4'h7)
      && fmt_parity_odd == link_8bit
      && fmt_stop_bits == (link_8bit ? 2'h1 : 2'h2))
      else $error("wrong char format");
endmodule // mdf_chk

bind mdf_framer mdf_chk #(.CHAR_CYCLES(CHAR_CYCLES)) i_chk (.clk, .rst,
   .link_8bit, .rx_valid, .rx_char, .tx_valid, .tx_ready, .tx_char,
   .tx_empty, .drv_en, .fmt_data_bits, .fmt_parity_odd, .fmt_stop_bits,
   .rx_msg_ok, .rx_msg_drop, .rx_wake, .rx_ack);

// file: verification/mdf_uart_model.sv
// Transmit side of the serial engine facing the framer
module mdf_uart_model (
   input wire clk,
   input wire rst,
   input wire slow,
   input wire tx_valid,
   input wire [7:0] tx_char,
   output logic tx_ready,
   output wire tx_empty
);
   timeunit 1ns;
   timeprecision 1ps;
   integer seed = 32'hb257;
   logic [3:0] busy_q;
   // ==========
   // Shifter busy six cycles per char
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_q <= 4'h0;
         tx_ready <= 1'b1;
      end else begin
         if (tx_valid && tx_ready)
            busy_q <= 4'h6;
         else if (busy_q != 4'h0)
            busy_q <= busy_q - 4'h1;
         tx_ready <= !slow || ($random(seed) & 32'h1);
      end
   end
   assign tx_empty = busy_q == 4'h0;
endmodule // mdf_uart_model

// file: verification/mdf_framer_bench.sv
// Self-checking bench of the multidrop framer
module mdf_framer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CC = 20;
   logic clk, rst, link_8bit, guard_omit, nodata_en, rx_valid, rx_perr;
   logic msg_valid, msg_last, slow;
   logic [7:0] unit_number, rx_char, msg_data, d;
   wire tx_valid, tx_ready, tx_empty, drv_en, fmt_parity_odd, msg_ready;
   wire rx_data_valid, rx_msg_ok, rx_msg_drop, rx_bcast, rx_wake, rx_ack;
   wire [7:0] tx_char, rx_data;
   wire [3:0] fmt_data_bits;
   wire [1:0] fmt_stop_bits;
   integer n_errors = 0, checks_done = 0, seed = 32'hb257;
   int n_ok = 0, n_drop = 0, n_wake = 0, n_ack = 0;
   logic [7:0] exp_tx[$], exp_rx[$], body[$];
   logic [7:0] un[6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
   logic [7:0] sq[6] = '{8'h35, 8'h35, 8'h30, 8'h30, 8'h37, 8'h34};
   logic [7:0] bd[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h5a, 8'h00};
   int okc[6] = '{1, 0, 1, 1, 0, 1};
   int drc[6] = '{0, 1, 0, 0, 1, 0};

   mdf_framer #(.CHAR_CYCLES(CC)) i_dut (.clk, .rst, .unit_number,
      .link_8bit, .guard_omit, .nodata_en, .rx_valid, .rx_char, .rx_perr,
      .tx_valid, .tx_ready, .tx_char, .tx_empty, .drv_en, .fmt_data_bits,
      .fmt_parity_odd, .fmt_stop_bits, .msg_valid, .msg_ready, .msg_data,
      .msg_last, .rx_data_valid, .rx_data, .rx_msg_ok, .rx_msg_drop,
      .rx_bcast, .rx_wake, .rx_ack);
   mdf_uart_model i_uart (.clk, .rst, .slow, .tx_valid, .tx_char,
      .tx_ready, .tx_empty);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========
   // Helpers
   function automatic logic [7:0] hx(input logic [3:0] n);
      return n < 4'ha ? 8'h30 + n : 8'h37 + n;
   endfunction
   function automatic logic [7:0] lrc(input logic [7:0] q[$]);
      logic [7:0] x = 8'h00;
      foreach (q[i]) x ^= q[i];
      return x;
   endfunction
   task automatic chk_char(input string nm, input logic [7:0] e, g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_flag(input string nm, input int e, g);
      checks_done++;
      if (g != e) begin
         n_errors++;
         $display("ERROR %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic put(input logic [7:0] c, input logic pe);
      @(posedge clk) #1;
      rx_valid = 1'b1;
      rx_char = c;
      rx_perr = pe;
      @(posedge clk) #1;
      rx_valid = 1'b0;
      rx_perr = 1'b0;
   endtask
   task automatic msg(input logic [7:0] u, ty, bad, input logic pe,
                      input logic [7:0] b[$]);
      logic [7:0] x;
      logic [7:0] f[$];
      f = {hx(u[7:4]), hx(u[3:0]), 8'h30, ty};
      f = {f, b};
      x = lrc(f) ^ bad;
      f = {8'hff, 8'h02, f, hx(x[7:4]), hx(x[3:0]), 8'h0d};
      foreach (f[i]) put(f[i], pe && i == 3);
   endtask
   task automatic reply(input logic [7:0] ty, input logic [7:0] b[$]);
      logic [7:0] x;
      logic [7:0] f[$];
      f = {8'h30, 8'h31, 8'h30, ty};
      f = {f, b};
      x = lrc(f);
      f = {8'h02, f, hx(x[7:4]), hx(x[3:0]), 8'h0d};
      if (guard_omit !== 1'b1) exp_tx.push_back(8'hff);
      foreach (f[i]) exp_tx.push_back(f[i]);
   endtask
   task automatic push(input int n);
      for (int i = 0; i < n; i++) begin
         msg_valid = 1'b1;
         msg_data = 8'h41 + ($random(seed) & 8'h0f);
         msg_last = i == n - 1;
         body.push_back(msg_data);
         while (msg_ready !== 1'b1) @(posedge clk) #1;
         @(posedge clk) #1;
      end
      msg_valid = 1'b0;
   endtask
   task automatic settle(input int ok, dr, wk, ak);
      repeat (3 * CC) @(posedge clk);
      for (int i = 0; i < 400 && (drv_en !== 1'b0 || exp_tx.size()); i++)
         @(posedge clk);
      chk_flag("tx_left", 0, exp_tx.size());
      chk_flag("rx_left", 0, exp_rx.size());
      chk_flag("rx_msg_ok", ok, n_ok);
      chk_flag("rx_msg_drop", dr, n_drop);
      chk_flag("rx_wake", wk, n_wake);
      chk_flag("rx_ack", ak, n_ack);
      {n_ok, n_drop, n_wake, n_ack} = '0;
      #1;
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ==========
   // Output watcher
   always @(posedge clk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         chk_char("tx_char", exp_tx.size() ? exp_tx.pop_front() : 8'hxx,
            tx_char);
      if (rx_data_valid === 1'b1)
         chk_char("rx_data", exp_rx.size() ? exp_rx.pop_front() : 8'hxx,
            rx_data);
      n_ok += rx_msg_ok === 1'b1;
      n_drop += rx_msg_drop === 1'b1;
      n_wake += rx_wake === 1'b1;
      n_ack += rx_ack === 1'b1;
   end

   initial begin
      repeat (30000) @(posedge clk);
      n_errors++;
      $display("ERROR watchdog expected end seen timeout");
      report_and_stop;
   end

   // ==========
   // Scenarios
   initial begin
      {rx_valid, rx_perr, msg_valid, msg_last, slow} = '0;
      {link_8bit, guard_omit, nodata_en} = 3'b001;
      {unit_number, rx_char, msg_data} = {8'h01, 16'h0000};
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      reply(8'h35, '{});
      msg(8'h01, 8'h31, 8'h00, 1'b0, '{});
      settle(0, 0, 0, 0);
      nodata_en = 1'b0;
      msg(8'h01, 8'h31, 8'h00, 1'b0, '{});
      settle(0, 0, 0, 0);
      foreach (un[i]) begin
         d = 8'h41 + ($random(seed) & 8'h0f);
         exp_rx.push_back(d);
         if (bd[i] == 8'h00 && un[i] == 8'h01) reply(8'h33, '{});
         msg(un[i], 8'h32, bd[i], 1'b0, '{sq[i], d});
         settle(okc[i], drc[i], 0, 0);
      end
      chk_char("rx_bcast", 8'h01, {7'h00, rx_bcast});
      nodata_en = 1'b1;
      msg(8'h01, 8'h36, 8'h00, 1'b0, '{});
      msg(8'h01, 8'h31, 8'h00, 1'b1, '{});
      msg(8'h02, 8'h31, 8'h00, 1'b0, '{});
      msg(8'h01, 8'h33, 8'h00, 1'b0, '{});
      settle(0, 0, 0, 1);
      msg(8'h00, 8'h34, 8'h00, 1'b0, '{});
      settle(0, 0, 1, 0);
      reply(8'h33, '{});
      msg(8'h01, 8'h34, 8'h00, 1'b0, '{});
      settle(0, 0, 1, 0);
      reply(8'h35, '{});
      put(8'h02, 1'b0);
      put(8'h39, 1'b0);
      msg(8'h01, 8'h31, 8'h00, 1'b0, '{});
      settle(0, 0, 0, 0);
      for (int k = 0; k < 11; k++) begin
         body.delete();
         body.push_back(k ? hx(4'((k - 1) % 9 + 1)) : 8'h30);
         push(k ? 1 : 32);
         if (k == 0)
            chk_char("msg_ready", 8'h00, {7'h00, msg_ready});
         slow = k == 0;
         reply(8'h32, body);
         msg(8'h01, 8'h31, 8'h00, 1'b0, '{});
         settle(0, 0, 0, 0);
      end
      guard_omit = 1'b1;
      reply(8'h35, '{});
      msg(8'h01, 8'h31, 8'h00, 1'b0, '{});
      settle(0, 0, 0, 0);
      rst = 1'b1;
      link_8bit = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      repeat (2) @(posedge clk);
      chk_char("fmt_data_bits", 8'h08, {4'h0, fmt_data_bits});
      chk_char("fmt_stop_bits", 8'h01, {6'h00, fmt_stop_bits});
      report_and_stop;
   end
endmodule // mdf_framer_bench
